/* File: verilog/bio_port.sv */
// Sixteen-bit parallel input/output port with handshake flags
`timescale 1ns/1ps
module bio_port
   import bio_pkg::*;
(
   input wire logic i_ref_clk, // 125 MHz clock
   input wire logic i_srst, // Synchronous reset, high
   input wire bio_hreq_s i_hreq, // Host bus request
   output logic o_hwr_ready, // Output word write accepted
   output logic [BIO_DW-1:0] o_hrdata, // Host read data
   output logic o_hrdata_valid, // Read data present, pulse
   input wire logic [BIO_DW-1:0] i_in_lines, // Input pins
   input wire bio_hs_pins_s i_hs_pins, // Handshake/control pins
   output logic [BIO_DW-1:0] o_out_lines, // Output pin levels
   output logic [BIO_DW-1:0] o_out_lines_oe, // Output pin enables
   output logic o_out_data_avail_flag, // Output strobe line
   output logic o_in_clear_flag // Input clear-to-send line
);

   // ****************************************************
   // Helpers
   // ****************************************************

   // Per-bit update: only bits in the change mask are written
   function automatic logic [BIO_DW-1:0] bio_apply_changes(
      input logic [BIO_DW-1:0] cur,
      input logic [BIO_DW-1:0] nxt
   );
      logic [BIO_DW-1:0] diff;
      diff = cur ^ nxt;
      return cur ^ diff;
   endfunction

   // Map select, address and direction onto one operation
   function automatic bio_op_e bio_decode(input bio_hreq_s req);
      bio_op_e op;
      op = BIO_OP_NONE;
      if (!req.sel_n) begin
         if (req.addr == BIO_ADDR_CTL_STAT) begin
            op = req.rd_dir ? BIO_OP_STAT_RD : BIO_OP_CTL_WR;
         end else if (req.addr == BIO_ADDR_WORD) begin
            op = req.rd_dir ? BIO_OP_IN_RD : BIO_OP_OUT_WR;
         end
      end
      return op;
   endfunction

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   logic [BIO_DW-1:0] in_lines_s;
   bio_hs_pins_s hs_s;

   // Reset to the pulled-up level so an idle port reads all ones
   bio_sync #(
      .W(BIO_DW),
      .RST_VAL(BIO_IN_RESET)
   ) u_sync_in (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_async(i_in_lines),
      .o_sync(in_lines_s)
   );

   bio_sync #(
      .W(4),
      .RST_VAL({4{BIO_PIN_IDLE}})
   ) u_sync_hs (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_async(i_hs_pins),
      .o_sync(hs_s)
   );

   // ****************************************************
   // Operation decode
   // ****************************************************
   bio_op_e op;
   wire ctl_write_op;
   wire stat_read_op;
   wire outword_write_op;
   wire inword_read_op;
   wire any_read_op;

   assign op = bio_decode(i_hreq);
   assign ctl_write_op = (op == BIO_OP_CTL_WR);
   assign stat_read_op = (op == BIO_OP_STAT_RD);
   assign outword_write_op = (op == BIO_OP_OUT_WR);
   assign inword_read_op = (op == BIO_OP_IN_RD);
   assign any_read_op = stat_read_op || inword_read_op;

   // ****************************************************
   // Control register
   // ****************************************************
   // The flags only reach their pins; nothing in the data path
   // looks at them, so software owns the whole protocol.
   logic [1:0] ctl_reg;
   logic [1:0] ctl_next;

   assign ctl_next = ctl_write_op
      ? {i_hreq.wdata[BIO_CTL_IN_CLEAR_BIT],
         i_hreq.wdata[BIO_CTL_OUT_AVAIL_BIT]}
      : ctl_reg;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         ctl_reg <= BIO_CTL_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign o_out_data_avail_flag = ctl_reg[0];
   assign o_in_clear_flag = ctl_reg[1];

   // ****************************************************
   // Status view
   // ****************************************************
   wire [BIO_DW-1:0] stat_word;

   assign stat_word = {{(BIO_DW-2){1'b0}}, hs_s.out_ready,
      hs_s.in_valid};

   // ****************************************************
   // Input register
   // ****************************************************
   // Tracks the pins while freeze is high; the first cycle it is
   // seen low the register stops, so it keeps the last sample
   // taken before the freeze edge. Two sync stages add latency.
   logic [BIO_DW-1:0] in_word_reg;
   logic [BIO_DW-1:0] in_word_next;

   assign in_word_next = hs_s.freeze_n ? in_lines_s
      : in_word_reg;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         in_word_reg <= BIO_IN_RESET;
      end else begin
         in_word_reg <= in_word_next;
      end
   end

   // ****************************************************
   // Output word path
   // ****************************************************
   // Writes pass a two-entry buffer. It drains while the drivers
   // are enabled; with the gate low it holds up to two words and
   // then refuses further writes through o_hwr_ready.
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [BIO_DW-1:0] buf_out_data;
   logic [BIO_DW-1:0] out_word_reg;
   logic [BIO_DW-1:0] out_word_next;

   bio_buf2 #(
      .W(BIO_DW),
      .DEPTH(BIO_FIFO_DEPTH)
   ) u_out_buf (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_valid(outword_write_op),
      .o_ready(buf_in_ready),
      .i_data(i_hreq.wdata),
      .o_valid(buf_out_valid),
      .i_ready(buf_out_ready),
      .o_data(buf_out_data)
   );

   assign buf_out_ready = hs_s.drive_en_n;
   assign o_hwr_ready = buf_in_ready;

   assign out_word_next = (buf_out_valid && buf_out_ready)
      ? bio_apply_changes(out_word_reg, buf_out_data)
      : out_word_reg;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         out_word_reg <= BIO_OUT_RESET;
      end else begin
         out_word_reg <= out_word_next;
      end
   end

   assign o_out_lines = out_word_reg;
   assign o_out_lines_oe = {BIO_DW{hs_s.drive_en_n}};

   // ****************************************************
   // Read data
   // ****************************************************
   wire [BIO_DW-1:0] rd_mux;
   logic [BIO_DW-1:0] rdata_reg;
   logic rvalid_reg;

   assign rd_mux = stat_read_op ? stat_word
      : (inword_read_op ? in_word_reg : BIO_RDATA_RESET);

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         rdata_reg <= BIO_RDATA_RESET;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= any_read_op ? rd_mux : rdata_reg;
         rvalid_reg <= any_read_op;
      end
   end

   assign o_hrdata = rdata_reg;
   assign o_hrdata_valid = rvalid_reg;

endmodule

/* File: verilog/bio_pkg.sv */
// Shared constants and carrier types of the parallel I/O port block
package bio_pkg;

   // ****************************************************
   // Widths
   // ****************************************************
   localparam int BIO_DW = 16;
   localparam int BIO_AW = 3;
   localparam int BIO_FIFO_DEPTH = 2;

   // Device number that the select strobe stands for
   localparam int BIO_UNIT_NUMBER = 8;

   // ****************************************************
   // Word addresses, qualified by the read direction
   // ****************************************************
   localparam logic [BIO_AW-1:0] BIO_ADDR_CTL_STAT = 3'h0;
   localparam logic [BIO_AW-1:0] BIO_ADDR_WORD = 3'h1;

   // ****************************************************
   // Field positions of handshake_control
   // ****************************************************
   localparam int BIO_CTL_OUT_AVAIL_BIT = 0;
   localparam int BIO_CTL_IN_CLEAR_BIT = 1;

   // Field positions of handshake_status
   localparam int BIO_STAT_IN_VALID_BIT = 0;
   localparam int BIO_STAT_OUT_READY_BIT = 1;

   // ****************************************************
   // Reset values (input, handshake and flag lines idle true, pulled up; output word and read data reset to zero)
   // ****************************************************
   localparam logic [1:0] BIO_CTL_RESET = 2'h3;
   localparam logic [BIO_DW-1:0] BIO_IN_RESET = 16'hFFFF;
   localparam logic [BIO_DW-1:0] BIO_OUT_RESET = 16'h0000;
   localparam logic [BIO_DW-1:0] BIO_RDATA_RESET = 16'h0000;
   localparam logic BIO_PIN_IDLE = 1'b1;

   // ****************************************************
   // Carrier types
   // ****************************************************
   typedef struct packed {
      logic sel_n;
      logic [BIO_AW-1:0] addr;
      logic rd_dir;
      logic [BIO_DW-1:0] wdata;
   } bio_hreq_s;

   typedef struct packed {
      logic in_valid;
      logic out_ready;
      logic freeze_n;
      logic drive_en_n;
   } bio_hs_pins_s;

   typedef enum logic [2:0] {
      BIO_OP_NONE,
      BIO_OP_CTL_WR,
      BIO_OP_STAT_RD,
      BIO_OP_OUT_WR,
      BIO_OP_IN_RD
   } bio_op_e;

endpackage

/* File: verilog/bio_sync.sv */
// Two-flop synchroniser for pin levels, reset to the idle level
`timescale 1ns/1ps
module bio_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_ref_clk, // Clock
   input wire logic i_srst, // Synchronous reset
   input wire logic [W-1:0] i_async, // Pin level
   output logic [W-1:0] o_sync // Synchronised level
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // First stage feeds only the second stage
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule

/* File: verilog/bio_buf2.sv */
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module bio_buf2 #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   input wire logic i_ref_clk, // Clock
   input wire logic i_srst, // Synchronous reset
   input wire logic i_valid, // Fill side valid
   output logic o_ready, // Fill side ready
   input wire logic [W-1:0] i_data, // Fill side data
   output logic o_valid, // Drain side valid
   input wire logic i_ready, // Drain side ready
   output logic [W-1:0] o_data // Drain side data
);

   localparam int PW = $clog2(DEPTH);
   // Full count sized to the counter; a pointer-wide cast would wrap to 0
   localparam logic [PW:0] FULL_CNT = DEPTH[PW:0];

   logic [W-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] cnt_reg;
   logic push;
   logic pop;

   assign o_ready = (cnt_reg != FULL_CNT);
   assign o_valid = (cnt_reg != '0);
   assign o_data = mem_reg[rd_ptr_reg];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_data;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
         rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
         cnt_reg <= cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end

endmodule

/* File: verification/bio_port_assertions.sv */
// Bus and pin timing checker of the parallel port
`timescale 1ns/1ps
module bio_port_checker
   import bio_pkg::*;
(
   input wire logic i_ref_clk, // Clock
   input wire logic i_srst, // Reset
   input wire bio_hreq_s i_hreq, // Host request
   input wire logic o_hwr_ready, // Write ready
   input wire logic [BIO_DW-1:0] o_hrdata, // Read data
   input wire logic o_hrdata_valid, // Read pulse
   input wire logic [BIO_DW-1:0] i_in_lines, // Input pins
   input wire bio_hs_pins_s i_hs_pins, // Control pins
   input wire logic [BIO_DW-1:0] o_out_lines, // Output levels
   input wire logic [BIO_DW-1:0] o_out_lines_oe, // Output enables
   input wire logic o_out_data_avail_flag, // Avail flag
   input wire logic o_in_clear_flag // Clear flag
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   wire sel = !i_hreq.sel_n && (i_hreq.addr <= BIO_ADDR_WORD);
   wire rd = sel && i_hreq.rd_dir;
   wire wr = sel && !i_hreq.rd_dir;
   wire ctl_wr = wr && (i_hreq.addr == BIO_ADDR_CTL_STAT);
   wire out_wr = wr && (i_hreq.addr == BIO_ADDR_WORD) && o_hwr_ready;
   wire stat_rd = rd && (i_hreq.addr == BIO_ADDR_CTL_STAT);
   wire [1:0] flags = {o_in_clear_flag, o_out_data_avail_flag};
   wire [15:0] all_on = 16'hFFFF;
   a_read_pulse: assert property (rd |=> o_hrdata_valid)
      else $error("read gave no data pulse");
   a_no_stray: assert property (!rd |=> !o_hrdata_valid)
      else $error("data pulse without a mapped read");
   a_ctl_latch: assert property (ctl_wr |=>
      flags == $past(i_hreq.wdata[1:0]))
      else $error("control write not latched");
   a_flags_hold: assert property (!ctl_wr |=> $stable(flags))
      else $error("flags moved without a control write");
   a_stat_upper: assert property (stat_rd |=>
      o_hrdata[15:2] == 14'h0000)
      else $error("status upper bits not zero");
   a_gate_float: assert property (!i_hs_pins.drive_en_n [*3] |->
      o_out_lines_oe == 16'h0000)
      else $error("outputs driven while gated off");
   a_gate_drive: assert property (i_hs_pins.drive_en_n [*3] |->
      o_out_lines_oe == all_on)
      else $error("outputs floating while gated on");
   // Only quiet, ungated writes are timed: queued words would come first
   a_out_lands: assert property (out_wr && !$past(out_wr)
      && !$past(out_wr, 2) && $past(o_out_lines_oe) == all_on
      && $past(o_out_lines_oe, 2) == all_on |-> ##2
      ($past(o_out_lines_oe) != all_on || o_out_lines_oe != all_on
      || o_out_lines == $past(i_hreq.wdata, 2)))
      else $error("written word not on output lines");
endmodule

bind bio_port bio_port_checker chk_u (.i_ref_clk(i_ref_clk),
   .i_srst(i_srst), .i_hreq(i_hreq), .o_hwr_ready(o_hwr_ready),
   .o_hrdata(o_hrdata), .o_hrdata_valid(o_hrdata_valid),
   .i_in_lines(i_in_lines), .i_hs_pins(i_hs_pins),
   .o_out_lines(o_out_lines), .o_out_lines_oe(o_out_lines_oe),
   .o_out_data_avail_flag(o_out_data_avail_flag),
   .o_in_clear_flag(o_in_clear_flag));

/* File: verification/bio_far_model.sv */
// Behavioural far-side device of the parallel port
`timescale 1ns/1ps
module bio_far_model
   import bio_pkg::*;
(
   input wire logic i_ref_clk, // Clock
   input wire logic i_attached, // Device plugged in
   input wire logic [1:0] i_lag, // Cycles before sending
   input wire logic [BIO_DW-1:0] i_word, // Word to send
   input wire logic i_freeze_n, // Freeze line level
   input wire logic i_gate_n, // Drive enable level
   input wire logic [BIO_DW-1:0] i_out_lines, // Port outputs
   input wire logic [BIO_DW-1:0] i_out_oe, // Port enables
   input wire logic i_avail, // Data available line
   input wire logic i_clear, // Clear-to-send line
   output logic [BIO_DW-1:0] o_in_lines, // Input pins
   output bio_hs_pins_s o_pins, // Handshake pins
   output logic [BIO_DW-1:0] o_taken // Last word taken
);
   logic [2:0] wait_reg = 3'h0;
   always @(posedge i_ref_clk) begin
      if (!i_attached || !i_clear) begin
         wait_reg <= 3'h0;
      end else if (wait_reg <= {1'b0, i_lag}) begin
         wait_reg <= wait_reg + 3'h1;
      end
      if (i_avail && i_out_oe == 16'hFFFF) begin
         o_taken <= i_out_lines;
      end
   end
   wire sent = wait_reg > {1'b0, i_lag};
   // Before sending, lines show the inverse so stale data never matches
   assign o_in_lines = !i_attached ? 16'hFFFF :
      (sent ? i_word : ~i_word);
   // Busy while the port still flags a word as available; idles true
   assign o_pins = {!i_attached || sent, !i_attached || !i_avail,
      i_freeze_n, i_gate_n};
endmodule

/* File: verification/binary_io_port_handshake_tb_top.sv */
// Self-checking bench of the parallel port
`timescale 1ns/1ps
module binary_io_port_handshake_tb_top import bio_pkg::*;;
   logic clk = 1'b0;
   logic srst = 1'b1;
   bio_hreq_s hreq = {1'b1, 3'h0, 1'b0, 16'h0000};
   logic att = 1'b0;
   logic frz_n = 1'b1;
   logic gate_n = 1'b1;
   logic [15:0] word = 16'h5A3C;
   logic hwr_rdy, rvalid, avail, clear;
   logic [15:0] rdata, in_lines, out_lines, oe, taken;
   bio_hs_pins_s pins;
   int errors = 0;
   int compares = 0;
   always #4 clk = ~clk;
   bio_port dut_u (.i_ref_clk(clk), .i_srst(srst), .i_hreq(hreq),
      .o_hwr_ready(hwr_rdy), .o_hrdata(rdata), .o_hrdata_valid(rvalid),
      .i_in_lines(in_lines), .i_hs_pins(pins), .o_out_lines(out_lines),
      .o_out_lines_oe(oe), .o_out_data_avail_flag(avail),
      .o_in_clear_flag(clear));
   bio_far_model far_u (.i_ref_clk(clk), .i_attached(att), .i_lag(2'h2),
      .i_word(word), .i_freeze_n(frz_n), .i_gate_n(gate_n),
      .i_out_lines(out_lines), .i_out_oe(oe), .i_avail(avail),
      .i_clear(clear), .o_in_lines(in_lines), .o_pins(pins),
      .o_taken(taken));
   task automatic complete_run;
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Leaves the request up so back-to-back calls assign it once a step
   task automatic op(input logic [2:0] a, input logic r, input logic [15:0] w);
      hreq = {1'b0, a, r, w};
      @(posedge clk);
      #1;
   endtask
   task automatic idle(input int n);
      hreq.sel_n = 1'b1;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] exp);
      op(a, 1'b1, 16'h0000);
      cmp({15'h0000, rvalid}, 16'h0001);
      cmp(rdata, exp);
   endtask
   // ******
   // Scenarios
   // ******
   initial begin
      repeat (2) @(posedge clk);
      #1;
      srst = 1'b0;
      idle(4);
      rd(3'h1, 16'hFFFF);
      rd(3'h0, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         op(3'h0, 1'b0, 16'(i));
         cmp({14'h0000, clear, avail}, 16'(i));
         rd(3'h1, 16'hFFFF);
      end
      op(3'h7, 1'b1, 16'h0000);
      cmp({15'h0000, rvalid}, 16'h0000);
      op(3'h2, 1'b0, 16'h0000);
      cmp({14'h0000, clear, avail}, 16'h0003);
      op(3'h0, 1'b0, 16'h0000);
      att = 1'b1;
      idle(6);
      rd(3'h1, ~16'h5A3C);
      rd(3'h0, 16'h0002);
      op(3'h0, 1'b0, 16'h0002);
      idle(8);
      rd(3'h1, 16'h5A3C);
      rd(3'h0, 16'h0003);
      frz_n = 1'b0;
      idle(4);
      word = 16'hC3A5;
      idle(6);
      rd(3'h1, 16'h5A3C);
      frz_n = 1'b1;
      idle(6);
      rd(3'h1, 16'hC3A5);
      op(3'h1, 1'b0, 16'hA5C3);
      idle(3);
      cmp(out_lines, 16'hA5C3);
      cmp(oe, 16'hFFFF);
      op(3'h1, 1'b0, 16'hA5C2);
      hreq.sel_n = 1'b1;
      repeat (3) begin
         @(posedge clk);
         #1;
         cmp(out_lines & 16'hFFFE, 16'hA5C2);
      end
      cmp(out_lines, 16'hA5C2);
      op(3'h0, 1'b0, 16'h0003);
      idle(2);
      cmp(taken, 16'hA5C2);
      rd(3'h0, 16'h0001);
      gate_n = 1'b0;
      idle(4);
      cmp(oe, 16'h0000);
      op(3'h1, 1'b0, 16'h1111);
      op(3'h1, 1'b0, 16'h2222);
      cmp({15'h0000, hwr_rdy}, 16'h0000);
      op(3'h1, 1'b0, 16'h3333);
      cmp(out_lines, 16'hA5C2);
      gate_n = 1'b1;
      idle(6);
      cmp(out_lines, 16'h2222);
      cmp({15'h0000, hwr_rdy}, 16'h0001);
      cmp(taken, 16'h2222);
      complete_run();
   end
   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      complete_run();
   end
endmodule
